// File: rtl/tcc_pkg.sv
/*
 * shared constants for the timer capture/compare/pwm channel.
 * assumes a byte-wide register model placed in the low lane of 32-bit apb words.
 */
package tcc_pkg;

    // ----------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL = 6'h19; // channel status and control
    localparam logic [5:0] IDX_VAL_HI = 6'h1a; // channel value, high byte
    localparam logic [5:0] IDX_VAL_LO = 6'h1b; // channel2_value_low
    localparam logic [5:0] IDX_PVAL_HI = 6'h1d; // channel3_value_high (partner)
    localparam logic [5:0] IDX_PVAL_LO = 6'h1e; // channel3_value_low (partner)

    // ----------------------------------------------------------------
    // control byte field positions
    // ----------------------------------------------------------------
    localparam int unsigned BIT_FLAG = 7; // channel_event_flag
    localparam int unsigned BIT_IRQ_EN = 6; // channel_irq_en
    localparam int unsigned BIT_BUF = 5; // buffered_mode_sel
    localparam int unsigned BIT_UNBUF = 4; // unbuffered_mode_sel
    localparam int unsigned BIT_ELS_HI = 3; // edge_level_sel_hi
    localparam int unsigned BIT_ELS_LO = 2; // edge_level_sel_lo
    localparam int unsigned BIT_TOV = 1; // overflow_toggle_en
    localparam int unsigned BIT_MAX = 0; // full_duty_force

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // edge/level field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] ELS_OFF = 2'h0; // pin under port control
    localparam logic [1:0] ELS_RISE = 2'h1; // capture rising / toggle
    localparam logic [1:0] ELS_FALL = 2'h2; // capture falling / clear
    localparam logic [1:0] ELS_BOTH = 2'h3; // capture any / set

endpackage : tcc_pkg

// File: rtl/tcc_pin_sync.sv
/*
 * two-flop synchroniser for the channel pin input.
 * assumes an asynchronous level input and one clock domain.
 */
module tcc_pin_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic meta; // first stage, read only by the second stage
        logic sync; // second stage
    } tcc_sync_state_t;

    tcc_sync_state_t state_reg; // registered state
    tcc_sync_state_t state_next; // next state

    // shift one stage per clock
    always_comb
    begin
        state_next.meta = async_in;
        state_next.sync = state_reg.meta;
    end

    // register; reset value of the pin level is low
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.sync;

endmodule : tcc_pin_sync

// File: rtl/tcc_channel.sv
/*
 * one 16-bit capture/compare/pwm timer channel with apb register access,
 * plus the partner value register used as second buffer in buffered mode.
 * assumes the shared counter, its wrap pulse and the halt level come from
 * logic on sys_clk; the channel pin arrives asynchronously.
 */
// Our own choice: register access over APB.
// Notes on behaviour
// - field 00 presets level from mode-A bit
// - capture on rising, falling or either edge
// - unbuffered compare: none, toggle, clear, set pin
// - buffered compare: toggle, clear or set pin
// - overflow toggles pin when toggle bit set
// - toggle bit ignored in capture mode
// - overflow action beats same-cycle compare action
// - full-duty bit forces pin high with clear and toggle bit set
// - full-duty change applies from next period
// - 16-bit value register, two byte accesses
// - value registers not reset
// - high byte read blocks capture until low read
// - high byte write blocks compare until low write
// - reset clears toggle-on-overflow bit
// - flag sets on event, read-then-write-0 clears
// - buffered mode disables partner channel and pin
// - halted counter blocks captures
// - pin driven only when field nonzero
module tcc_channel (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shared timer state
    input wire logic [15:0] counter_value,
    input wire logic counter_wrap,
    input wire logic counter_halt,
    // channel pin
    input wire logic channel_pin_in,
    output logic channel_pin_out,
    output logic channel_pin_oe_n,
    // to the rest of the timer
    output logic channel_irq,
    output logic partner_disable
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl; // status and control byte
        logic flag_armed; // flag was read as set
        logic cap_lock; // captures blocked until low byte read
        logic cmp_lock; // compares blocked until low byte written
        logic max_active; // full duty, sampled at wrap
        logic level; // internal output level
        logic active_sel; // buffered: 1 = partner register active
        logic pending; // buffered: new register waits for wrap
        logic pending_sel; // buffered: which register was written last
        logic pin_q; // previous synchronised pin level
        logic [15:0] cnt_prev; // counter one clock ago
        logic [31:0] rdata; // read data
        logic ready; // access phase answer
        logic slverr; // unmapped address
        logic pin_out; // pin output level
        logic pin_oe_n; // pin enable, low while driving
        logic irq; // interrupt request
        logic partner_off; // partner channel disabled
    } tcc_state_t;

    // value registers kept apart: they carry no reset
    typedef struct packed {
        logic [15:0] val; // own channel value
        logic [15:0] pval; // partner channel value
    } tcc_data_t;

    tcc_state_t state_reg; // registered control state
    tcc_state_t state_next; // next control state
    tcc_data_t data_reg; // registered values
    tcc_data_t data_next; // next values
    logic pin_sync; // synchronised pin level

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    tcc_pin_sync u_pin_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in(channel_pin_in),
        .sync_out(pin_sync)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [5:0] idx; // word index of the access
        logic setup; // apb setup cycle
        logic acc; // apb transfer completes this edge
        logic wr; // completed write on lane 0
        logic rd; // completed read
        logic [1:0] els; // edge/level field
        logic buf_mode; // buffered compare
        logic cmp_mode; // any compare mode
        logic cap_mode; // input capture
        logic rise; // pin rising edge
        logic fall; // pin falling edge
        logic cap_hit; // active capture edge
        logic [15:0] cmp_val; // active compare value
        logic cmp_hit; // compare match event
        logic event_set; // flag set source
        logic mapped; // address decodes
        logic [7:0] rbyte; // selected read byte
        logic lvl; // working output level
        idx = paddr[7:2];
        setup = psel & ~penable;
        acc = psel & penable & state_reg.ready;
        wr = acc & pwrite & pstrb[0];
        rd = acc & ~pwrite;
        state_next = state_reg;
        data_next = data_reg;
        els = state_reg.ctrl[tcc_pkg::BIT_ELS_HI:tcc_pkg::BIT_ELS_LO];
        buf_mode = state_reg.ctrl[tcc_pkg::BIT_BUF];
        cmp_mode = buf_mode | state_reg.ctrl[tcc_pkg::BIT_UNBUF];
        cap_mode = ~cmp_mode & (els != tcc_pkg::ELS_OFF);
        lvl = state_reg.level;

        // edge detection on the synchronised pin
        rise = pin_sync & ~state_reg.pin_q;
        fall = ~pin_sync & state_reg.pin_q;
        state_next.pin_q = pin_sync;
        state_next.cnt_prev = counter_value;

        // capture: edge select, halted or locked captures ignored
        unique case (els)
            tcc_pkg::ELS_RISE: cap_hit = rise;
            tcc_pkg::ELS_FALL: cap_hit = fall;
            tcc_pkg::ELS_BOTH: cap_hit = rise | fall;
            default: cap_hit = 1'b0;
        endcase
        cap_hit = cap_hit & cap_mode & ~counter_halt & ~state_reg.cap_lock;
        if (cap_hit)
        begin
            data_next.val = counter_value;
        end

        // compare: one event per new counter value, blocked while locked
        cmp_val = (buf_mode & state_reg.active_sel) ? data_reg.pval : data_reg.val;
        cmp_hit = cmp_mode & ~state_reg.cmp_lock & (counter_value == cmp_val)
                  & (counter_value != state_reg.cnt_prev);

        // output level: presets while disconnected, actions while connected
        if (els == tcc_pkg::ELS_OFF)
        begin
            lvl = ~state_reg.ctrl[tcc_pkg::BIT_UNBUF];
        end
        else if (cmp_mode & counter_wrap & state_reg.ctrl[tcc_pkg::BIT_TOV])
        begin
            // wrap beats a same-cycle match; full duty holds the pin high
            if (state_reg.ctrl[tcc_pkg::BIT_MAX] & (els == tcc_pkg::ELS_FALL))
            begin
                lvl = 1'b1;
            end
            else
            begin
                lvl = ~state_reg.level;
            end
        end
        else if (cmp_hit)
        begin
            unique case (els)
                tcc_pkg::ELS_RISE: lvl = ~state_reg.level;
                tcc_pkg::ELS_FALL: lvl = state_reg.max_active ? 1'b1 : 1'b0;
                default: lvl = 1'b1;
            endcase
        end
        state_next.level = lvl;

        // full duty only changes at a period boundary
        if (counter_wrap)
        begin
            state_next.max_active = state_reg.ctrl[tcc_pkg::BIT_MAX] & state_reg.ctrl[tcc_pkg::BIT_TOV]
                                    & (els == tcc_pkg::ELS_FALL);
        end

        // buffered pair: the last written register takes over at wrap
        if (counter_wrap & buf_mode & state_reg.pending)
        begin
            state_next.active_sel = state_reg.pending_sel;
            state_next.pending = 1'b0;
        end

        // read side effects
        if (rd & (idx == tcc_pkg::IDX_CTRL))
        begin
            state_next.flag_armed = state_reg.rdata[tcc_pkg::BIT_FLAG];
        end
        if (rd & cap_mode & (idx == tcc_pkg::IDX_VAL_HI))
        begin
            state_next.cap_lock = 1'b1;
        end
        if (rd & (idx == tcc_pkg::IDX_VAL_LO))
        begin
            state_next.cap_lock = 1'b0;
        end

        // register writes
        if (wr)
        begin
            unique case (idx)
                tcc_pkg::IDX_CTRL:
                begin
                    state_next.ctrl[6:0] = pwdata[6:0];
                    // clear only after a read saw the flag set
                    if (~pwdata[tcc_pkg::BIT_FLAG] & state_reg.flag_armed)
                    begin
                        state_next.ctrl[tcc_pkg::BIT_FLAG] = 1'b0;
                    end
                    state_next.flag_armed = 1'b0;
                end
                tcc_pkg::IDX_VAL_HI:
                begin
                    data_next.val[15:8] = pwdata[7:0];
                    state_next.cmp_lock = cmp_mode;
                end
                tcc_pkg::IDX_VAL_LO:
                begin
                    data_next.val[7:0] = pwdata[7:0];
                    state_next.cmp_lock = 1'b0;
                    state_next.pending = 1'b1;
                    state_next.pending_sel = 1'b0;
                end
                tcc_pkg::IDX_PVAL_HI:
                begin
                    data_next.pval[15:8] = pwdata[7:0];
                    state_next.cmp_lock = cmp_mode;
                end
                tcc_pkg::IDX_PVAL_LO:
                begin
                    data_next.pval[7:0] = pwdata[7:0];
                    state_next.cmp_lock = 1'b0;
                    state_next.pending = 1'b1;
                    state_next.pending_sel = 1'b1;
                end
                default:
                begin
                    state_next.slverr = state_reg.slverr;
                end
            endcase
        end

        // a new event sets the flag and cancels a pending clear
        event_set = cap_hit | cmp_hit;
        if (event_set)
        begin
            state_next.ctrl[tcc_pkg::BIT_FLAG] = 1'b1;
            state_next.flag_armed = 1'b0;
        end

        // apb answer: prepared in setup, presented for one access cycle
        mapped = (idx == tcc_pkg::IDX_CTRL) | (idx == tcc_pkg::IDX_VAL_HI)
                 | (idx == tcc_pkg::IDX_VAL_LO) | (idx == tcc_pkg::IDX_PVAL_HI)
                 | (idx == tcc_pkg::IDX_PVAL_LO);
        unique case (idx)
            tcc_pkg::IDX_CTRL: rbyte = state_reg.ctrl;
            tcc_pkg::IDX_VAL_HI: rbyte = data_reg.val[15:8];
            tcc_pkg::IDX_VAL_LO: rbyte = data_reg.val[7:0];
            tcc_pkg::IDX_PVAL_HI: rbyte = data_reg.pval[15:8];
            tcc_pkg::IDX_PVAL_LO: rbyte = data_reg.pval[7:0];
            default: rbyte = 8'h00;
        endcase
        state_next.ready = setup;
        if (setup)
        begin
            state_next.rdata = {24'h00_0000, rbyte};
            state_next.slverr = ~mapped;
        end
        else if (acc)
        begin
            state_next.rdata = tcc_pkg::RDATA_RESET;
            state_next.slverr = 1'b0;
        end

        // pin drive only while connected to a compare function
        state_next.pin_oe_n = ~(cmp_mode & (els != tcc_pkg::ELS_OFF));
        state_next.pin_out = lvl;
        state_next.irq = state_next.ctrl[tcc_pkg::BIT_FLAG]
                         & state_next.ctrl[tcc_pkg::BIT_IRQ_EN];
        state_next.partner_off = state_next.ctrl[tcc_pkg::BIT_BUF];
    end

    // ----------------------------------------------------------------
    // control state register; reset clears all bits except level, pin_out and pin_oe_n, which go high
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= '0;
            state_reg.ctrl <= tcc_pkg::CTRL_RESET;
            state_reg.pin_oe_n <= 1'b1;
            state_reg.level <= 1'b1;
            state_reg.pin_out <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // value registers; left unreset so content after reset is unknown
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        data_reg <= data_next;
    end

    // ----------------------------------------------------------------
    // outputs straight from flops
    // ----------------------------------------------------------------
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign channel_pin_out = state_reg.pin_out;
    assign channel_pin_oe_n = state_reg.pin_oe_n;
    assign channel_irq = state_reg.irq;
    assign partner_disable = state_reg.partner_off;

endmodule : tcc_channel

// File: test/tcc_channel_props.sv
/*
 * port checker for the capture/compare channel.
 * assumes a bind from the bench top and one clock domain.
 */
module tcc_channel_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // timer and pin
    input wire logic [15:0] counter_value,
    input wire logic counter_wrap,
    input wire logic channel_pin_out,
    input wire logic channel_pin_oe_n,
    input wire logic channel_irq,
    input wire logic partner_disable
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    logic [15:0] cnt_q; // counter one cycle ago
    wire acc_wr = psel & penable & pwrite; // completing write
    wire cnt_moved = counter_value != cnt_q; // match needs a moving counter
    // last counter value, for the moved test
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= 16'h0;
        else
            cnt_q <= counter_value;
    end
    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    AST_RDATA_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data nonzero");
    AST_ERR_READY: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready");
    AST_PARTNER_WR: assert property ($changed(partner_disable) |-> $past(acc_wr))
        else $error("partner disable moved alone");
    // enable follows the registered control byte, so it moves two edges after the write
    AST_DRIVE_WR: assert property ($fell(channel_pin_oe_n) |-> $past(acc_wr, 2))
        else $error("pin driven without setup");
    AST_PIN_CAUSE: assert property ($changed(channel_pin_out) |-> $past(acc_wr)
        || $past(acc_wr, 2) || $past(counter_wrap) || $past(counter_wrap, 2)
        || $past(cnt_moved) || $past(cnt_moved, 2))
        else $error("pin moved without cause");
    AST_IRQ_FALL: assert property ($fell(channel_irq) |-> $past(acc_wr) || $past(acc_wr, 2))
        else $error("irq dropped without write");
    // main scenarios
    cover property ($rose(channel_irq));
    cover property ($fell(channel_pin_oe_n));
    cover property (pslverr);
endmodule : tcc_channel_props

// File: test/tcc_pin_model.sv
/*
 * external source on the channel pin.
 * assumes the bench asks for levels; output is a clean level.
 */
module tcc_pin_model (
    // clock
    input wire logic sys_clk,
    // requested level and pacing
    input wire logic want,
    input wire logic slow,
    // level on the pin
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned hold = 0; // edges since last change
    initial pin = 1'b1;
    // one change, then a rest so the channel sees a stable pin
    always @(posedge sys_clk)
    begin
        hold <= hold + 1;
        if (want != pin && hold >= (slow ? 5 : 2))
        begin
            pin <= want;
            hold <= 0;
        end
    end
endmodule : tcc_pin_model

// File: test/tb_top.sv
/*
 * self-checking bench for the capture/compare channel.
 * assumes the package indexes and a pin model on the far side.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] CT = tcc_pkg::IDX_CTRL;
    localparam logic [5:0] VH = tcc_pkg::IDX_VAL_HI;
    localparam logic [5:0] VL = tcc_pkg::IDX_VAL_LO;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite, counter_wrap, counter_halt, want, slow;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [15:0] counter_value;
    logic pready, pslverr, pin_out, pin_oe_n, irq, part_dis, model_pin, err;
    wire pin_lvl = pin_oe_n ? model_pin : pin_out; // shared pin wire
    int n_errors = 0;
    int num_checks = 0;
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    tcc_channel i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
        .counter_wrap(counter_wrap), .counter_halt(counter_halt), .channel_pin_in(pin_lvl),
        .channel_pin_out(pin_out), .channel_pin_oe_n(pin_oe_n), .channel_irq(irq),
        .partner_disable(part_dis));
    tcc_pin_model i_pin (.sys_clk(sys_clk), .want(want), .slow(slow), .pin(model_pin));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    // one apb transfer, held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_errors++;
            close_out();
        end
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk({24'h0, q}, {24'h0, exp});
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    // counter runs 0..n, so a stored value of 5 matches once
    task automatic tick(input int n);
        @(posedge sys_clk) counter_value <= 16'h0;
        repeat (n) @(posedge sys_clk) counter_value <= counter_value + 16'h1;
        settle();
    endtask : tick
    // overflow pulse, landing the counter on v
    task automatic wrap(input logic [15:0] v);
        @(posedge sys_clk);
        counter_value <= v;
        counter_wrap <= 1'b1;
        @(posedge sys_clk) counter_wrap <= 1'b0;
        settle();
    endtask : wrap
    // pin edge with the counter set just before it
    task automatic edge_at(input logic [15:0] c, input logic lvl);
        @(posedge sys_clk);
        counter_value <= c;
        want <= lvl;
        repeat (12) @(posedge sys_clk);
    endtask : edge_at
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, counter_value} = '0;
        {counter_wrap, counter_halt, slow, want, pstrb} = {4'h1, 4'h1};
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(CT, tcc_pkg::CTRL_RESET);
        chk({pin_oe_n, pin_out, irq, part_dis}, 4'hc);
        apb(1'b0, 6'h00, 8'h00);
        chk({err, q}, 9'h100);
        wr(VH, 8'h12);
        wr(VL, 8'h34);
        wr(tcc_pkg::IDX_PVAL_HI, 8'h56);
        wr(tcc_pkg::IDX_PVAL_LO, 8'h78);
        rd(VH, 8'h12);
        rd(VL, 8'h34);
        rd(tcc_pkg::IDX_PVAL_HI, 8'h56);
        rd(tcc_pkg::IDX_PVAL_LO, 8'h78);
        wr(CT, 8'h10);
        settle();
        chk(pin_out, 1'b0);
        $display("test registers done");
        // toggle, clear, set; preset opposite to the action
        for (int e = 1; e < 4; e++)
        begin
            wr(CT, e == 2 ? 8'h00 : 8'h10);
            wr(VH, 8'h00);
            wr(VL, 8'h05);
            wr(CT, {4'h5, e[1:0], 2'h0});
            tick(8);
            chk({pin_out, pin_oe_n, irq}, {e != 2, 2'b01});
            rd(CT, {4'hd, e[1:0], 2'h0});
            wr(CT, {4'hd, e[1:0], 2'h0});
            rd(CT, {4'hd, e[1:0], 2'h0});
            wr(CT, {4'h5, e[1:0], 2'h0});
            rd(CT, {4'h5, e[1:0], 2'h0});
        end
        wr(CT, 8'h14);
        wr(VH, 8'h00);
        tick(8);
        rd(CT, 8'h14);
        wr(VL, 8'h05);
        tick(8);
        rd(CT, 8'h94);
        wr(tcc_pkg::IDX_PVAL_HI, 8'h00);
        wr(tcc_pkg::IDX_PVAL_LO, 8'h03);
        wr(CT, 8'h24);
        wrap(16'h0);
        tick(4);
        rd(CT, 8'ha4);
        chk(pin_out, 1'b1);
        chk(part_dis, 1'b1);
        $display("test compare done");
        wr(CT, 8'h1e);
        tick(8);
        wrap(16'h5);
        chk(pin_out, 1'b0);
        wrap(16'h0);
        chk(pin_out, 1'b1);
        wr(CT, 8'h1b);
        wrap(16'h0);
        tick(8);
        chk(pin_out, 1'b1);
        wr(CT, 8'h1a);
        tick(8);
        chk(pin_out, 1'b1);
        wrap(16'h0);
        tick(8);
        chk(pin_out, 1'b0);
        $display("test overflow done");
        // rising, falling, either edge; toggle bit set throughout
        for (int e = 1; e < 4; e++)
        begin
            slow <= (e == 3);
            wr(CT, {4'h0, e[1:0], 2'h2});
            edge_at(16'h1111, 1'b0);
            wrap(16'h0);
            edge_at(16'h2222, 1'b1);
            chk(pin_oe_n, 1'b1);
            rd(VH, e == 2 ? 8'h11 : 8'h22);
            rd(VL, e == 2 ? 8'h11 : 8'h22);
        end
        rd(VH, 8'h22);
        edge_at(16'h3333, 1'b0);
        rd(VL, 8'h22);
        counter_halt <= 1'b1;
        edge_at(16'h4444, 1'b1);
        rd(VH, 8'h22);
        rd(VL, 8'h22);
        counter_halt <= 1'b0;
        $display("test capture done");
        close_out();
    end
    // watchdog against a hang
    initial
    begin
        repeat (50000) @(posedge sys_clk);
        n_errors++;
        close_out();
    end
endmodule : tb_top
bind tcc_channel tcc_channel_props i_props (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_value(counter_value), .counter_wrap(counter_wrap),
    .channel_pin_out(channel_pin_out), .channel_pin_oe_n(channel_pin_oe_n),
    .channel_irq(channel_irq), .partner_disable(partner_disable));
